// >>> hsr_params.svh
// Constants for the hub status request handler: request codes, feature
// selectors, field positions, reply length and register offsets.
// Included by the package and by both ends.
`ifndef HSR_PARAMS_SVH
`define HSR_PARAMS_SVH

// ----------------------------------------------------------------------
// Setup fields
// ----------------------------------------------------------------------
`define HSR_RT_HUB_STATUS   8'hA0
`define HSR_RT_PORT_STATUS  8'hA3
`define HSR_RT_CLEAR_HUB    8'h20
`define HSR_RT_SET_HUB      8'h20
`define HSR_REQ_GET_STATUS  8'h00
`define HSR_REQ_CLEAR_FEAT  8'h01
`define HSR_REQ_SET_FEAT    8'h03
`define HSR_REPLY_LEN       16'h0004
`define HSR_FSEL_LOCAL_PWR  16'h0000
`define HSR_FSEL_OVER_CUR   16'h0001

// ----------------------------------------------------------------------
// Status and change bit positions
// ----------------------------------------------------------------------
`define HSR_BIT_LOCAL_PWR   0
`define HSR_BIT_OVER_CUR    1

// ----------------------------------------------------------------------
// Controller register offsets on APB (byte addresses)
// ----------------------------------------------------------------------
`define HSR_OFS_SETUP_LO    12'h000
`define HSR_OFS_SETUP_HI    12'h004
`define HSR_OFS_CTRL        12'h008
`define HSR_OFS_STATUS      12'h00C
`define HSR_OFS_REPLY       12'h010
`define HSR_CTRL_GO_BIT     0
`define HSR_STAT_BUSY_BIT   0
`define HSR_STAT_DONE_BIT   1
`define HSR_STAT_ERR_BIT    2

`endif

// >>> hsr_pkg.sv
// Types shared by both ends of the hub status request handler.
// Assumes hsr_params.svh sits in the include path.
`include "hsr_params.svh"
package hsr_pkg;
    // Eight-byte control setup, fields as sent on the bus
    typedef struct packed {
        logic [15:0] length;
        logic [15:0] index;
        logic [15:0] value;
        logic [7:0]  request;
        logic [7:0]  req_type;
    } hsr_setup_t;

    // Handshake result of a request
    typedef enum logic [1:0] {HSR_ACK, HSR_STALL, HSR_NONE} hsr_result_t;
endpackage

// >>> hsr_if.sv
// Interface joining the host-side controller and the hub status logic.
// A setup is offered with req_valid; one answer comes back with
// rsp_valid, and for accepted status queries four data bytes follow.
`timescale 1ns/1ps
interface hsr_if;
    import hsr_pkg::*;
    logic        req_valid;
    hsr_setup_t  setup;
    logic        rsp_valid;
    logic        rsp_stall;
    logic        dat_valid;
    logic [7:0]  dat_byte;
    logic        dat_last;

    modport device (
        input  req_valid,
        input  setup,
        output rsp_valid,
        output rsp_stall,
        output dat_valid,
        output dat_byte,
        output dat_last
    );
    modport host (
        output req_valid,
        output setup,
        input  rsp_valid,
        input  rsp_stall,
        input  dat_valid,
        input  dat_byte,
        input  dat_last
    );
endinterface

// >>> hsr_hub_end.sv
// Hub end: answers hub and port GET_STATUS, hub feature set/clear,
// keeps the hub status and change words.
// Assumes one clock pclk; hardware condition inputs synchronous to it.
//
// Contract
// - Hub query A0h, zero fields, four bytes
// - Bad hub query fields give request error
// - Host ignores answers while unconfigured
// - Status bit 0 is 1 when supply lost
// - Hub over-current bit tracks summed current
// - Per-port or no detection keeps bit 1 zero
// - Bits 2 to 15 read zero
// - Status bits never changed by requests
// - Supply change sets change bit 0
// - Over-current change sets change bit 1
// - Bus reset clears change bits
// - Optional diagnostic set of change bits
// - Unsupported set gives error or no-op
// - Clear feature acknowledges change bit
// - Redundant set or clear succeeds unchanged
// - Port query A3h, port index, four bytes
// - Host names existing nonzero port
// - Port change bits mirror status positions
// - Bad port query fields give request error
// - Selector 0 local power, 1 over-current
`timescale 1ns/1ps
`include "hsr_params.svh"
module hsr_hub_end
    import hsr_pkg::*;
#(
    parameter int NPORTS       = 4,
    parameter bit HUB_OC       = 1'b1,  // Over-current reported hub-wide
    parameter bit DIAG_SET     = 1'b1,  // Allow set of change bits
    parameter bit SET_STALLS   = 1'b0   // Unsupported set: stall or no-op
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    hsr_if.device                  link,
    input  wire logic              bus_reset,
    input  wire logic              supply_lost,
    input  wire logic              hub_over_current,
    input  wire logic [NPORTS*16-1:0] port_status,
    input  wire logic [NPORTS*16-1:0] port_change,
    output logic                   ports_power_off
);
    typedef enum logic [1:0] {ST_IDLE, ST_SEND} st_t;

    typedef struct packed {
        st_t         st;
        logic [15:0] hub_status_word;
        logic [15:0] hub_change_word;
        logic [31:0] reply;
        logic [1:0]  cnt;
        logic        rsp_valid;
        logic        rsp_stall;
        logic        dat_valid;
        logic [7:0]  dat_byte;
        logic        dat_last;
        logic        power_off;
    } hsr_hub_t;

    hsr_hub_t s_r;
    hsr_hub_t s_nxt;

    // Port number valid when nonzero and present
    function automatic logic port_ok(input logic [15:0] idx);
        port_ok = (idx[15:8] == 8'h00) && (idx[7:0] != 8'h00) &&
                  (int'(idx[7:0]) <= NPORTS);
    endfunction

    // ----------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------
    always_comb
    begin
        logic [15:0] st_new;
        logic [15:0] pst;
        logic [15:0] pch;
        logic        is_get;
        logic        is_ch;
        logic        is_set;
        int          pidx;
        st_new = 16'h0000;
        pst    = 16'h0000;
        pch    = 16'h0000;
        is_get = 1'b0;
        is_ch  = 1'b0;
        is_set = 1'b0;
        pidx   = 0;
        s_nxt  = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.rsp_stall = 1'b0;
        s_nxt.dat_valid = 1'b0;
        s_nxt.dat_last  = 1'b0;

        // Status follows hardware only; reserved bits stay zero
        st_new[`HSR_BIT_LOCAL_PWR] = supply_lost;
        st_new[`HSR_BIT_OVER_CUR]  = HUB_OC ? hub_over_current
                                            : 1'b0;
        s_nxt.hub_status_word = st_new;
        s_nxt.power_off = HUB_OC && hub_over_current;

        // Change bits: sticky set on edge; clear loses to a new edge
        if (st_new[0] != s_r.hub_status_word[0])
            s_nxt.hub_change_word[0] = 1'b1;
        if (st_new[1] != s_r.hub_status_word[1])
            s_nxt.hub_change_word[1] = 1'b1;

        case (s_r.st)
            ST_IDLE:
            begin
                if (link.req_valid)
                begin
                    is_get = link.setup.request == `HSR_REQ_GET_STATUS;
                    is_ch  = link.setup.request == `HSR_REQ_CLEAR_FEAT;
                    is_set = link.setup.request == `HSR_REQ_SET_FEAT;
                    s_nxt.rsp_valid = 1'b1;
                    if (is_get &&
                        link.setup.req_type == `HSR_RT_HUB_STATUS)
                    begin
                        if (link.setup.value == 16'h0000 &&
                            link.setup.index == 16'h0000 &&
                            link.setup.length == `HSR_REPLY_LEN)
                        begin
                            // Both words taken in the same cycle
                            s_nxt.reply = {s_r.hub_change_word,
                                           s_r.hub_status_word};
                            s_nxt.st = ST_SEND;
                        end
                        else
                            s_nxt.rsp_stall = 1'b1;
                    end
                    else if (is_get &&
                             link.setup.req_type == `HSR_RT_PORT_STATUS)
                    begin
                        if (link.setup.value == 16'h0000 &&
                            link.setup.length == `HSR_REPLY_LEN &&
                            port_ok(link.setup.index))
                        begin
                            pidx = int'(link.setup.index[7:0]) - 1;
                            pst = port_status[pidx*16 +: 16];
                            pch = port_change[pidx*16 +: 16];
                            s_nxt.reply = {pch, pst};
                            s_nxt.st = ST_SEND;
                        end
                        else
                            s_nxt.rsp_stall = 1'b1;
                    end
                    else if ((is_ch || is_set) &&
                             link.setup.req_type == `HSR_RT_CLEAR_HUB &&
                             link.setup.index == 16'h0000 &&
                             link.setup.length == 16'h0000 &&
                             link.setup.value[15:1] == 15'h0000)
                    begin
                        // Selector 0 or 1; redundant ops succeed
                        if (is_ch)
                            s_nxt.hub_change_word[link.setup.value[0]] =
                                1'b0;
                        else if (DIAG_SET)
                            s_nxt.hub_change_word[link.setup.value[0]] =
                                1'b1;
                        else
                            s_nxt.rsp_stall = SET_STALLS;
                        // Edge in this same cycle still sets
                        if (st_new[0] != s_r.hub_status_word[0])
                            s_nxt.hub_change_word[0] = 1'b1;
                        if (st_new[1] != s_r.hub_status_word[1])
                            s_nxt.hub_change_word[1] = 1'b1;
                    end
                    else
                        s_nxt.rsp_stall = 1'b1;
                end
            end
            ST_SEND:
            begin
                // Low byte of each word first
                s_nxt.dat_valid = 1'b1;
                s_nxt.dat_byte  = s_r.reply[s_r.cnt*8 +: 8];
                s_nxt.dat_last  = s_r.cnt == 2'd3;
                s_nxt.cnt       = s_r.cnt + 2'd1;
                if (s_r.cnt == 2'd3)
                    s_nxt.st = ST_IDLE;
            end
            default:
                s_nxt.st = ST_IDLE;
        endcase

        // Bus reset wins over everything for the change word
        if (bus_reset)
            s_nxt.hub_change_word = 16'h0000;
        s_nxt.hub_change_word[15:2] = 14'h0000;
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '{st: ST_IDLE, default: '0};
        else
            s_r <= s_nxt;
    end

    assign link.rsp_valid  = s_r.rsp_valid;
    assign link.rsp_stall  = s_r.rsp_stall;
    assign link.dat_valid  = s_r.dat_valid;
    assign link.dat_byte   = s_r.dat_byte;
    assign link.dat_last   = s_r.dat_last;
    assign ports_power_off = s_r.power_off;

endmodule // hsr_hub_end

// >>> hsr_host_end.sv
// Host end: APB slave registers that hold a setup; GO issues it on the
// link and the answer is collected into status and reply registers.
// Assumes one clock pclk and a well-behaved APB master.
`timescale 1ns/1ps
`include "hsr_params.svh"
module hsr_host_end
    import hsr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    hsr_if.host              link
);
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_DATA} hs_t;

    typedef struct packed {
        hs_t         st;
        hsr_setup_t  setup;
        logic        req_valid;
        logic        done;
        logic        err;
        logic [31:0] reply;
        logic [1:0]  cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } hsr_host_t;

    hsr_host_t h_r;
    hsr_host_t h_nxt;

    // ----------------------------------------------------------------------
    // Next state: APB access completes two cycles after setup (one wait state)
    // ----------------------------------------------------------------------
    always_comb
    begin
        logic acc;
        acc   = psel && penable && !h_r.pready;
        h_nxt = h_r;
        h_nxt.pready    = acc;
        h_nxt.pslverr   = 1'b0;
        h_nxt.req_valid = 1'b0;
        if (acc && !pwrite)
        begin
            case (paddr)
                `HSR_OFS_SETUP_LO: h_nxt.prdata = h_r.setup[31:0];
                `HSR_OFS_SETUP_HI: h_nxt.prdata = h_r.setup[63:32];
                `HSR_OFS_STATUS:   h_nxt.prdata = {29'h0, h_r.err, h_r.done,
                                                   h_r.st != HS_IDLE};
                `HSR_OFS_REPLY:    h_nxt.prdata = h_r.reply;
                `HSR_OFS_CTRL:     h_nxt.prdata = 32'h0000_0000;
                default:
                begin
                    h_nxt.prdata  = 32'h0000_0000;
                    h_nxt.pslverr = 1'b1;
                end
            endcase
        end
        else if (acc)
        begin
            h_nxt.prdata = 32'h0000_0000;
            case (paddr)
                `HSR_OFS_SETUP_LO: h_nxt.setup[31:0]  = pwdata;
                `HSR_OFS_SETUP_HI: h_nxt.setup[63:32] = pwdata;
                `HSR_OFS_STATUS:   h_nxt.pslverr = 1'b0;
                `HSR_OFS_REPLY:    h_nxt.pslverr = 1'b0;
                `HSR_OFS_CTRL:
                begin
                    // GO ignored while a request is outstanding
                    if (pwdata[`HSR_CTRL_GO_BIT] && h_r.st == HS_IDLE)
                    begin
                        h_nxt.req_valid = 1'b1;
                        h_nxt.done  = 1'b0;
                        h_nxt.err   = 1'b0;
                        h_nxt.reply = 32'h0000_0000;
                        h_nxt.cnt   = 2'd0;
                        h_nxt.st    = HS_WAIT;
                    end
                end
                default: h_nxt.pslverr = 1'b1;
            endcase
        end

        // ------------------------------------------------------------------
        // Link side: answer, then four bytes low first for good queries
        // ------------------------------------------------------------------
        case (h_r.st)
            HS_IDLE: ;
            HS_WAIT:
            begin
                if (link.rsp_valid)
                begin
                    h_nxt.err = link.rsp_stall;
                    if (link.rsp_stall ||
                        h_r.setup.request != `HSR_REQ_GET_STATUS)
                    begin
                        h_nxt.done = 1'b1;
                        h_nxt.st   = HS_IDLE;
                    end
                    else
                        h_nxt.st = HS_DATA;
                end
            end
            HS_DATA:
            begin
                if (link.dat_valid)
                begin
                    h_nxt.reply[h_r.cnt*8 +: 8] = link.dat_byte;
                    h_nxt.cnt = h_r.cnt + 2'd1;
                    if (link.dat_last)
                    begin
                        h_nxt.done = 1'b1;
                        h_nxt.st   = HS_IDLE;
                    end
                end
            end
            default: h_nxt.st = HS_IDLE;
        endcase
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            h_r <= '{st: HS_IDLE, default: '0};
        else
            h_r <= h_nxt;
    end

    assign prdata         = h_r.prdata;
    assign pready         = h_r.pready;
    assign pslverr        = h_r.pslverr;
    assign link.req_valid = h_r.req_valid;
    assign link.setup     = h_r.setup;

endmodule // hsr_host_end

// >>> hsr_link_monitor.sv
// Checker for the link between host end and hub end.
// Takes the link signals as plain inputs; the bench instantiates it once.
`timescale 1ns/1ps
`include "hsr_params.svh"
module hsr_link_monitor
    import hsr_pkg::*;
#(
    parameter int NPORTS = 4
)(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       req_valid,
    input wire hsr_setup_t setup,
    input wire logic       rsp_valid,
    input wire logic       rsp_stall,
    input wire logic       dat_valid,
    input wire logic [7:0] dat_byte,
    input wire logic       dat_last
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    logic hub_q;
    logic hub_ok;
    logic port_q;
    logic port_ok;
    logic feat_ok;

    // Classify the offered setup; only meaningful while req_valid is high
    assign hub_q   = req_valid && setup.req_type == `HSR_RT_HUB_STATUS
                     && setup.request == `HSR_REQ_GET_STATUS;
    assign hub_ok  = hub_q && setup.value == 16'h0 && setup.index == 16'h0
                     && setup.length == `HSR_REPLY_LEN;
    assign port_q  = req_valid && setup.req_type == `HSR_RT_PORT_STATUS
                     && setup.request == `HSR_REQ_GET_STATUS;
    assign port_ok = port_q && setup.value == 16'h0 && setup.index != 16'h0
                     && setup.index <= NPORTS
                     && setup.length == `HSR_REPLY_LEN;
    assign feat_ok = req_valid && setup.req_type == `HSR_RT_CLEAR_HUB
                     && (setup.request == `HSR_REQ_CLEAR_FEAT
                     || setup.request == `HSR_REQ_SET_FEAT)
                     && setup.value <= 16'h1 && setup.index == 16'h0
                     && setup.length == 16'h0;

    // ------------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------------
    sequence s_four;
        (dat_valid && !dat_last) [*3] ##1 (dat_valid && dat_last);
    endsequence
    sequence s_reply;
        rsp_valid && !rsp_stall ##1 s_four;
    endsequence
    sequence s_refuse;
        rsp_valid && rsp_stall ##1 !dat_valid;
    endsequence

    a_rsp_follows_req: assert property (req_valid |=> rsp_valid)
        else $error("no answer one cycle after a request");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without a request");
    a_hub_query_ok: assert property (hub_ok |=> s_reply)
        else $error("hub query not answered with four bytes");
    a_port_query_ok: assert property (port_ok |=> s_reply)
        else $error("port query not answered with four bytes");
    a_hub_query_bad: assert property (hub_q && !hub_ok |=> s_refuse)
        else $error("bad hub query not refused");
    a_port_query_bad: assert property (port_q && !port_ok |=> s_refuse)
        else $error("bad port query not refused");
    a_reserved_zero: assert property (hub_ok ##1 rsp_valid |=>
        dat_byte[7:2] == 6'h0 ##1 dat_byte == 8'h0
        ##1 dat_byte[7:2] == 6'h0 ##1 dat_byte == 8'h0)
        else $error("reserved hub bits not zero");
    a_feature_ok: assert property (feat_ok |=>
        rsp_valid && !rsp_stall ##1 !dat_valid)
        else $error("valid hub feature request failed");
endmodule // hsr_link_monitor

// >>> test_hub_status_request_handler.sv
// Self-checking bench: APB drives the host end, which talks to the hub end.
// Hub condition inputs are driven directly; the link is watched as well.
`timescale 1ns/1ps
`include "hsr_params.svh"
module test_hub_status_request_handler;
    import hsr_pkg::*;
    localparam int NP = 4;

    // One row: {supply_lost, over_current}, setup, error and reply expected
    typedef struct packed {
        logic [1:0]  env;
        hsr_setup_t  s;
        logic        err;
        logic [31:0] rep;
    } hsr_row_t;

    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            bus_reset;
    logic            supply_lost;
    logic            hub_over_current;
    logic [NP*16-1:0] port_status;
    logic [NP*16-1:0] port_change;
    logic            ports_power_off;
    logic [31:0]     wire_q;
    hsr_row_t        rows[$];
    int              n_mismatch;
    int              checked;
    int              cycles;

    hsr_if link();
    hsr_host_end hsr_host_end_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    hsr_hub_end #(.NPORTS(NP)) hsr_hub_end_inst (.pclk(pclk),
        .presetn(presetn), .link(link), .bus_reset(bus_reset),
        .supply_lost(supply_lost), .hub_over_current(hub_over_current),
        .port_status(port_status), .port_change(port_change),
        .ports_power_off(ports_power_off));
    hsr_link_monitor #(.NPORTS(NP)) hsr_link_monitor_inst (.pclk(pclk),
        .presetn(presetn), .req_valid(link.req_valid), .setup(link.setup),
        .rsp_valid(link.rsp_valid), .rsp_stall(link.rsp_stall),
        .dat_valid(link.dat_valid), .dat_byte(link.dat_byte),
        .dat_last(link.dat_last));

    // ------------------------------------------------------------------
    // Clock, timeout and wire capture
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // About 28 requests of some 25 cycles each; a hang ends the run
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    // Bytes land low first, so the last four form {change, status}
    always @(posedge pclk)
        if (link.dat_valid === 1'b1)
            wire_q <= {link.dat_byte, wire_q[31:8]};

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load setup, fire GO, poll until idle and done, then fetch the reply
    task automatic send(input hsr_setup_t s, output logic [31:0] rep,
                        output logic e);
        logic [31:0] q;
        logic        x;
        apb(1'b1, `HSR_OFS_SETUP_LO, s[31:0], q, x);
        apb(1'b1, `HSR_OFS_SETUP_HI, s[63:32], q, x);
        apb(1'b1, `HSR_OFS_CTRL, 32'h1, q, x);
        q = 32'h1;
        for (int n = 0; n < 20 && (q[0] !== 1'b0 || q[1] !== 1'b1); n++)
            apb(1'b0, `HSR_OFS_STATUS, 32'h0, q, x);
        check({30'h0, q[1:0]}, 32'h2);
        e = q[2];
        apb(1'b0, `HSR_OFS_REPLY, 32'h0, rep, x);
    endtask

    task automatic add(input logic [1:0] env, input logic [7:0] rt,
        input logic [7:0] rq, input logic [15:0] v, input logic [15:0] ix,
        input logic [15:0] ln, input logic er, input logic [31:0] rp);
        rows.push_back('{env, '{ln, ix, v, rq, rt}, er, rp});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        hsr_row_t    r;
        logic [31:0] rep;
        logic        e;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_reset, supply_lost, hub_over_current} = 3'h0;
        for (int p = 0; p < NP; p++)
        begin
            port_status[p*16+:16] = 16'h0101 + 16'(p);
            port_change[p*16+:16] = 16'h0011 + 16'(p);
        end
        {n_mismatch, checked, cycles, wire_q} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0000_0000);
        add(2'h2, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0001_0001);
        add(2'h3, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0003_0003);
        add(2'h3, 8'h20, 8'h01, 16'h0, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h3, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0002_0003);
        add(2'h3, 8'h20, 8'h01, 16'h1, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h3, 8'h20, 8'h01, 16'h1, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h3, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0000_0003);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0003_0000);
        add(2'h0, 8'h20, 8'h01, 16'h0, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h0, 8'h20, 8'h01, 16'h1, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0000_0000);
        add(2'h0, 8'h20, 8'h03, 16'h0, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h0, 8'h20, 8'h03, 16'h0, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0001_0000);
        add(2'h0, 8'h20, 8'h03, 16'h1, 16'h0, 16'h0, 1'b0, 32'h0);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h4, 1'b0, 32'h0003_0000);
        add(2'h0, 8'hA0, 8'h00, 16'h1, 16'h0, 16'h4, 1'b1, 32'h0);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h1, 16'h4, 1'b1, 32'h0);
        add(2'h0, 8'hA0, 8'h00, 16'h0, 16'h0, 16'h2, 1'b1, 32'h0);
        add(2'h0, 8'hA3, 8'h00, 16'h0, 16'h0, 16'h4, 1'b1, 32'h0);
        add(2'h0, 8'hA3, 8'h00, 16'h0, 16'h5, 16'h4, 1'b1, 32'h0);
        add(2'h0, 8'hA3, 8'h00, 16'h1, 16'h1, 16'h4, 1'b1, 32'h0);
        add(2'h0, 8'hA3, 8'h00, 16'h0, 16'h1, 16'h5, 1'b1, 32'h0);
        add(2'h0, 8'h20, 8'h01, 16'h2, 16'h0, 16'h0, 1'b1, 32'h0);
        add(2'h0, 8'hA3, 8'h00, 16'h0, 16'h1, 16'h4, 1'b0, 32'h0011_0101);
        add(2'h0, 8'hA3, 8'h00, 16'h0, 16'h4, 16'h4, 1'b0, 32'h0014_0104);
        foreach (rows[i])
        begin
            r = rows[i];
            supply_lost      <= r.env[1];
            hub_over_current <= r.env[0];
            @(posedge pclk);
            send(r.s, rep, e);
            check({31'h0, e}, {31'h0, r.err});
            if (r.s.request == `HSR_REQ_GET_STATUS && !r.err)
            begin
                check(rep, r.rep);
                check(wire_q, r.rep);
            end
            check({31'h0, ports_power_off}, {31'h0, r.env[0]});
        end
        // Bus reset wipes the change bits left set by the rows above
        bus_reset <= 1'b1;
        @(posedge pclk);
        bus_reset <= 1'b0;
        send(rows[0].s, rep, e);
        check(rep, 32'h0);
        // Unmapped address is refused and reads zero
        apb(1'b0, 12'h100, 32'h0, rep, e);
        check({rep[30:0], e}, 32'h1);
        // Reset in mid-run clears the link and the controller status
        presetn <= 1'b0;
        @(posedge pclk);
        check({27'h0, link.rsp_valid, link.rsp_stall, link.dat_valid,
               link.dat_last, link.req_valid}, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `HSR_OFS_STATUS, 32'h0, rep, e);
        check(rep, 32'h0);
        close_out();
    end
endmodule // test_hub_status_request_handler
